// ---- hw/csr_call_status.v ----
`timescale 1ns/1ps
`include "csr_grp_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - All call group registers are sixteen bits wide.
// - Group has condition, rise and fall filters, event, enable, summary.
// - Condition bit 15 always reads zero.
// - Condition bit 5 follows the connected-state indicator.
// - Condition bit 4 follows the access-state indicator.
// - Condition bit 3 follows the paging-state indicator.
// - Condition bit 1 follows the registration-state indicator.
// - Condition bit 0 follows the active-state indicator.
// - Reading an event register returns it, then clears it.
// - Clear-status command clears the event registers.
// - Enable register is writable and readable; writing zero disables all.
// - Rise and fall filters are writable and readable back.
// - Questionable group offers the same operations through its own commands.
// - Summary is high when any enabled event bit is captured.
////////////////////////////////////////////////////////////////////////////////

module csr_call_status #(
  parameter WIDTH = 16
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             st_connect,
  input  wire             st_access,
  input  wire             st_page,
  input  wire             st_register,
  input  wire             st_active,
  input  wire [WIDTH-1:0] ques_cond_in,
  input  wire             cmd_valid,
  input  wire             cmd_write,
  input  wire             cmd_group,
  input  wire [2:0]       cmd_sel,
  input  wire [WIDTH-1:0] cmd_wdata,
  input  wire             clear_status,
  output reg              rsp_valid,
  output reg  [WIDTH-1:0] rsp_data,
  output reg              call_summary,
  output reg              ques_summary
);

////////////////////////////////////////////////////////////////////////////////
// Indicator pins come from another domain, so each passes two flip-flops.

  reg  [4:0]       ind_meta_q;
  reg  [4:0]       ind_sync_q;
  reg  [WIDTH-1:0] ques_meta_q;
  reg  [WIDTH-1:0] ques_sync_q;
  wire [WIDTH-1:0] call_cond_in;

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ind_meta_q  <= 5'h00;
      ind_sync_q  <= 5'h00;
      ques_meta_q <= {WIDTH{1'b0}};
      ques_sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      ind_meta_q  <= {st_connect, st_access, st_page, st_register, st_active};
      ind_sync_q  <= ind_meta_q;
      ques_meta_q <= ques_cond_in;
      ques_sync_q <= ques_meta_q;
    end
  end

  assign call_cond_in = {{(WIDTH-6){1'b0}},
                         ind_sync_q[4],
                         ind_sync_q[3],
                         ind_sync_q[2],
                         1'b0,
                         ind_sync_q[1],
                         ind_sync_q[0]};

////////////////////////////////////////////////////////////////////////////////
// Command decode.

  wire             is_call;
  wire             is_ques;
  wire             wr_ok;
  wire             rd_event;

  assign is_call  = cmd_valid & (cmd_group == `CSR_GRP_CALL);
  assign is_ques  = cmd_valid & (cmd_group == `CSR_GRP_QUES);
  assign wr_ok    = cmd_write;
  assign rd_event = ~cmd_write & (cmd_sel == `CSR_SEL_EVENT);

  wire [WIDTH-1:0] c_cond, c_rise, c_fall, c_event, c_en;
  wire [WIDTH-1:0] q_cond, q_rise, q_fall, q_event, q_en;
  wire             c_sum;
  wire             q_sum;

  csr_status_group #(
    .WIDTH     (WIDTH),
    .USED_MASK (`CSR_CALL_USED_MASK)
  ) u_call (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .cond_in      (call_cond_in),
    .wr_rise      (is_call & wr_ok & (cmd_sel == `CSR_SEL_RISE)),
    .wr_fall      (is_call & wr_ok & (cmd_sel == `CSR_SEL_FALL)),
    .wr_enable    (is_call & wr_ok & (cmd_sel == `CSR_SEL_ENABLE)),
    .wr_data      (cmd_wdata),
    .event_read   (is_call & rd_event),
    .clear_status (clear_status),
    .cond_q       (c_cond),
    .rise_q       (c_rise),
    .fall_q       (c_fall),
    .event_q      (c_event),
    .enable_q     (c_en),
    .summary      (c_sum)
  );

  csr_status_group #(
    .WIDTH     (WIDTH),
    .USED_MASK (`CSR_QUES_USED_MASK)
  ) u_ques (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .cond_in      (ques_sync_q),
    .wr_rise      (is_ques & wr_ok & (cmd_sel == `CSR_SEL_RISE)),
    .wr_fall      (is_ques & wr_ok & (cmd_sel == `CSR_SEL_FALL)),
    .wr_enable    (is_ques & wr_ok & (cmd_sel == `CSR_SEL_ENABLE)),
    .wr_data      (cmd_wdata),
    .event_read   (is_ques & rd_event),
    .clear_status (clear_status),
    .cond_q       (q_cond),
    .rise_q       (q_rise),
    .fall_q       (q_fall),
    .event_q      (q_event),
    .enable_q     (q_en),
    .summary      (q_sum)
  );

////////////////////////////////////////////////////////////////////////////////
// Read answer: registered one cycle after the query; event value is the
// pre-clear contents. Unknown selectors answer zero.

  reg [WIDTH-1:0] rd_mux;

  always @*
  begin
    rd_mux = {WIDTH{1'b0}};
    case (cmd_sel)
      `CSR_SEL_COND:   rd_mux = cmd_group ? c_cond  : q_cond;
      `CSR_SEL_RISE:   rd_mux = cmd_group ? c_rise  : q_rise;
      `CSR_SEL_FALL:   rd_mux = cmd_group ? c_fall  : q_fall;
      `CSR_SEL_EVENT:  rd_mux = cmd_group ? c_event : q_event;
      `CSR_SEL_ENABLE: rd_mux = cmd_group ? c_en    : q_en;
      default:         rd_mux = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp_valid    <= 1'b0;
      rsp_data     <= {WIDTH{1'b0}};
      call_summary <= 1'b0;
      ques_summary <= 1'b0;
    end
    else
    begin
      rsp_valid    <= cmd_valid & ~cmd_write;
      rsp_data     <= (cmd_valid & ~cmd_write) ? rd_mux : {WIDTH{1'b0}};
      call_summary <= c_sum;
      ques_summary <= q_sum;
    end
  end

endmodule

// ---- include/csr_grp_regs.vh ----
`ifndef CSR_GRP_REGS_VH
`define CSR_GRP_REGS_VH

// Group selectors carried on the command port.
`define CSR_GRP_QUES        1'b0
`define CSR_GRP_CALL        1'b1

// Register selectors within a group.
`define CSR_SEL_COND        3'h0
`define CSR_SEL_RISE        3'h1
`define CSR_SEL_FALL        3'h2
`define CSR_SEL_EVENT       3'h3
`define CSR_SEL_ENABLE      3'h4

// Call state condition bit positions.
`define CSR_BIT_ACTIVE      0
`define CSR_BIT_REGISTER    1
`define CSR_BIT_PAGE        3
`define CSR_BIT_ACCESS      4
`define CSR_BIT_CONNECT     5

// Bits that can ever be nonzero in the condition registers.
`define CSR_CALL_USED_MASK  16'h003b
`define CSR_QUES_USED_MASK  16'h0100

// Reset values.
`define CSR_RST_RISE        16'hffff
`define CSR_RST_FALL        16'h0000
`define CSR_RST_EVENT       16'h0000
`define CSR_RST_ENABLE      16'h0000

`endif

// ---- hw/csr_status_group.v ----
`timescale 1ns/1ps
`include "csr_grp_regs.vh"

module csr_status_group #(
  parameter WIDTH     = 16,
  parameter USED_MASK = 16'h0000
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] cond_in,
  input  wire             wr_rise,
  input  wire             wr_fall,
  input  wire             wr_enable,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             event_read,
  input  wire             clear_status,
  output wire [WIDTH-1:0] cond_q,
  output wire [WIDTH-1:0] rise_q,
  output wire [WIDTH-1:0] fall_q,
  output wire [WIDTH-1:0] event_q,
  output wire [WIDTH-1:0] enable_q,
  output wire             summary
);

  reg  [WIDTH-1:0] cond_r_q;
  reg  [WIDTH-1:0] rise_r_q;
  reg  [WIDTH-1:0] fall_r_q;
  reg  [WIDTH-1:0] event_r_q;
  reg  [WIDTH-1:0] enable_r_q;
  wire [WIDTH-1:0] cond_d;
  wire [WIDTH-1:0] hits;
  wire [WIDTH-1:0] event_d;
  wire [WIDTH-1:0] used;

  assign used    = USED_MASK;
  assign cond_d  = cond_in & used;
  assign hits    = ((cond_d & ~cond_r_q) & rise_r_q)
                 | ((~cond_d & cond_r_q) & fall_r_q);
  // A new edge in the same cycle as a read or clear is kept, not lost.
  assign event_d = ((event_read | clear_status) ? {WIDTH{1'b0}} : event_r_q)
                 | hits;

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cond_r_q   <= {WIDTH{1'b0}};
      rise_r_q   <= `CSR_RST_RISE;
      fall_r_q   <= `CSR_RST_FALL;
      event_r_q  <= `CSR_RST_EVENT;
      enable_r_q <= `CSR_RST_ENABLE;
    end
    else
    begin
      cond_r_q  <= cond_d;
      event_r_q <= event_d;
      if (wr_rise)
        rise_r_q <= wr_data;
      if (wr_fall)
        fall_r_q <= wr_data;
      if (wr_enable)
        enable_r_q <= wr_data;
    end
  end

  assign cond_q   = cond_r_q;
  assign rise_q   = rise_r_q;
  assign fall_q   = fall_r_q;
  assign event_q  = event_r_q;
  assign enable_q = enable_r_q;
  assign summary  = |(event_r_q & enable_r_q);

endmodule

// ---- bench/csr_call_status_props.sv ----
`timescale 1ns/1ps
`include "csr_grp_regs.vh"

module csr_call_status_props #(
  parameter WIDTH = 16
) (
  input wire             clock,
  input wire             sys_rst,
  input wire             st_connect,
  input wire             st_access,
  input wire             st_page,
  input wire             st_register,
  input wire             st_active,
  input wire [WIDTH-1:0] ques_cond_in,
  input wire             cmd_valid,
  input wire             cmd_write,
  input wire             cmd_group,
  input wire [2:0]       cmd_sel,
  input wire [WIDTH-1:0] cmd_wdata,
  input wire             clear_status,
  input wire             rsp_valid,
  input wire [WIDTH-1:0] rsp_data,
  input wire             call_summary,
  input wire             ques_summary
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire        rd_c = cmd_valid && !cmd_write;
  wire        wr_c = cmd_valid && cmd_write;
  wire [15:0] st_v = {10'h0, st_connect, st_access, st_page, 1'b0, st_register, st_active};
  a_query_answered:
    assert property (rd_c |=> rsp_valid) else $error("query got no answer");
  a_answer_has_cause:
    assert property (rsp_valid |-> $past(rd_c)) else $error("answer without query");
  a_write_silent:
    assert property (wr_c |=> !rsp_valid) else $error("write gave an answer");
  // Pins pass two sync stages, the condition register and the answer register,
  // so the answer mirrors the pins as they were four samples back.
  a_cond_mirror:
    assert property (rsp_valid && $past(rd_c && cmd_group && cmd_sel == 3'h0)
      |-> rsp_data == $past(st_v, 4))
      else $error("condition word does not mirror indicators");
  // The summary register is built from the event and enable registers, so it
  // follows a clear or an enable write one cycle after those registers do.
  a_clear_drops_sum:
    assert property (clear_status |-> ##2 !call_summary && !ques_summary)
      else $error("summary held after clear status");
  a_enable_zero_sum:
    assert property (wr_c && cmd_group && cmd_sel == 3'h4 && cmd_wdata == 16'h0
      |-> ##2 !call_summary) else $error("summary held with enable zero");
  a_read_clr_call:
    assert property (rd_c && cmd_group && cmd_sel == 3'h3 |-> ##2 !call_summary)
      else $error("call summary held after event read");
  a_read_clr_ques:
    assert property (rd_c && !cmd_group && cmd_sel == 3'h3 |-> ##2 !ques_summary)
      else $error("ques summary held after event read");
  cover property (rd_c && cmd_sel == 3'h3);
  cover property ($rose(call_summary));
  cover property ($rose(ques_summary));
endmodule

bind csr_call_status csr_call_status_props #(.WIDTH(WIDTH)) u_props (.clock(clock),
  .sys_rst(sys_rst), .st_connect(st_connect), .st_access(st_access), .st_page(st_page),
  .st_register(st_register), .st_active(st_active), .ques_cond_in(ques_cond_in),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_sel(cmd_sel),
  .cmd_wdata(cmd_wdata), .clear_status(clear_status), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .call_summary(call_summary), .ques_summary(ques_summary));

// ---- bench/csr_ctl_model.sv ----
`timescale 1ns/1ps

module csr_ctl_model (
  input  wire        clock,
  output reg         cmd_valid,
  output reg         cmd_write,
  output reg         cmd_group,
  output reg  [2:0]  cmd_sel,
  output reg  [15:0] cmd_wdata,
  input  wire        rsp_valid,
  input  wire [15:0] rsp_data
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_group = 1'b0;
    cmd_sel   = 3'h0;
    cmd_wdata = 16'h0;
  end
  // The answer is due exactly one cycle after the command edge; a late one reads as x.
  task xfer(input w, input g, input [2:0] s, input [15:0] d, output [15:0] q);
    begin
      @(posedge clock);
      #1;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_group = g;
      cmd_sel   = s;
      cmd_wdata = d;
      @(posedge clock);
      #1;
      cmd_valid = 1'b0;
      // Released data is inverted so that a late sample cannot look right.
      cmd_wdata = ~d;
      q = rsp_valid ? rsp_data : 16'hxxxx;
    end
  endtask
endmodule

// ---- bench/call_status_register_groups_tb_top.sv ----
`timescale 1ns/1ps
`include "csr_grp_regs.vh"

module call_status_register_groups_tb_top;
  reg         clock;
  reg         sys_rst;
  reg  [4:0]  sts;
  reg  [15:0] ques_in;
  reg         clear_status;
  reg  [15:0] q;
  wire        cmd_valid, cmd_write, cmd_group, rsp_valid, call_sum, ques_sum;
  wire [2:0]  cmd_sel;
  wire [15:0] cmd_wdata;
  wire [15:0] rsp_data;
  integer     miscompares;
  integer     checks_done;
  integer     i;
  csr_call_status dut (.clock(clock), .sys_rst(sys_rst), .st_connect(sts[4]),
    .st_access(sts[3]), .st_page(sts[2]), .st_register(sts[1]), .st_active(sts[0]),
    .ques_cond_in(ques_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_group(cmd_group), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .clear_status(clear_status), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .call_summary(call_sum), .ques_summary(ques_sum));
  csr_ctl_model ctl (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_group(cmd_group), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  ////////////////////////////////////////////////////////////////////
  task chk(input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task rd(input g, input [2:0] s, input [15:0] e);
    begin
      ctl.xfer(1'b0, g, s, 16'h0, q);
      chk(e, q);
    end
  endtask
  task wr(input g, input [2:0] s, input [15:0] d);
    ctl.xfer(1'b1, g, s, d, q);
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task cs;
    begin
      clear_status = 1'b1;
      @(posedge clock);
      #1;
      clear_status = 1'b0;
    end
  endtask
  task t_reset;
    for (i = 0; i < 2; i = i + 1)
    begin
      rd(i[0], `CSR_SEL_RISE, 16'hffff);
      rd(i[0], `CSR_SEL_FALL, 16'h0000);
      rd(i[0], `CSR_SEL_EVENT, 16'h0000);
      rd(i[0], `CSR_SEL_ENABLE, 16'h0000);
      rd(i[0], 3'h7, 16'h0000);
    end
  endtask
  task t_cond;
    for (i = 0; i < 32; i = i + 1)
    begin
      sts = i[4:0];
      wt(5);
      rd(`CSR_GRP_CALL, `CSR_SEL_COND, {10'h0, sts[4:2], 1'b0, sts[1:0]});
    end
  endtask
  task t_event;
    begin
      sts = 5'h0;
      wt(5);
      cs;
      wr(`CSR_GRP_CALL, `CSR_SEL_ENABLE, 16'hffff);
      sts[4] = 1'b1;
      wt(5);
      chk(16'h1, {15'h0, call_sum});
      rd(`CSR_GRP_CALL, `CSR_SEL_EVENT, 16'h0020);
      rd(`CSR_GRP_CALL, `CSR_SEL_EVENT, 16'h0000);
      wr(`CSR_GRP_CALL, `CSR_SEL_RISE, 16'h0000);
      wr(`CSR_GRP_CALL, `CSR_SEL_FALL, 16'h0020);
      rd(`CSR_GRP_CALL, `CSR_SEL_FALL, 16'h0020);
      sts[3] = 1'b1;
      sts[4] = 1'b0;
      wt(5);
      rd(`CSR_GRP_CALL, `CSR_SEL_EVENT, 16'h0020);
      sts[4] = 1'b1;
      wt(3);
      sts[4] = 1'b0;
      wt(5);
      cs;
      rd(`CSR_GRP_CALL, `CSR_SEL_EVENT, 16'h0000);
      sts[4] = 1'b1;
      wt(3);
      sts[4] = 1'b0;
      wt(5);
      wr(`CSR_GRP_CALL, `CSR_SEL_ENABLE, 16'h0000);
      wt(1);
      chk(16'h0, {15'h0, call_sum});
      rd(`CSR_GRP_CALL, `CSR_SEL_EVENT, 16'h0020);
    end
  endtask
  task t_ques;
    begin
      wr(`CSR_GRP_QUES, `CSR_SEL_ENABLE, 16'h0100);
      ques_in = 16'hffff;
      wt(5);
      rd(`CSR_GRP_QUES, `CSR_SEL_COND, 16'h0100);
      chk(16'h1, {15'h0, ques_sum});
      wr(`CSR_GRP_QUES, `CSR_SEL_FALL, 16'h1234);
      rd(`CSR_GRP_QUES, `CSR_SEL_FALL, 16'h1234);
      rd(`CSR_GRP_QUES, `CSR_SEL_EVENT, 16'h0100);
      rd(`CSR_GRP_QUES, `CSR_SEL_EVENT, 16'h0000);
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d mismatches=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    #1000000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  initial
  begin
    sys_rst = 1'b1;
    sts = 5'h0;
    ques_in = 16'h0;
    clear_status = 1'b0;
    miscompares = 0;
    checks_done = 0;
    wt(16);
    sys_rst = 1'b0;
    t_reset;
    t_cond;
    t_event;
    t_ques;
    print_verdict;
  end
endmodule
